// ### rtl/etp_top.sv
// Purpose: Machine check, internal fault, thermal limit and power-stable gating.
// Assumes: Error and thermal event inputs come from same-clock logic.
// Notes: Open-drain pins exposed as in/out/enable triples.
`timescale 1ns/1ns
module etp_top
    import etp_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         reset_n,
    input  wire logic                         power_stable,
    input  wire logic [etp_pkg::CFG_WIDTH-1:0] mc_config,
    input  wire logic                         internal_err,
    input  wire logic                         initiator_err,
    input  wire logic                         observed_err,
    input  wire logic                         die_at_limit,
    input  wire logic                         machine_check_error_n_in,
    output logic                              machine_check_error_n_out,
    output logic                              machine_check_error_n_oe,
    output logic                              internal_fault_n,
    output logic                              thermal_limit_n,
    output logic                              core_run,
    output logic                              mc_seen
);
    import etp_pkg::*;

    typedef struct packed {
        logic [1:0] rst_sync;   // Reset pin synchroniser
        logic       mc_drive;
        logic       fault;
        logic       hot;
        logic       run;
        logic [1:0] mc_in_sync; // Shared line synchroniser
        logic       seen;
    } etp_state_s;

    etp_state_s st_q, st_d;
    logic       pwr_sync;
    logic       live;

    // Power stable is asynchronous, so it is synchronised before use
    etp_sync u_pwr_sync (
        .sys_clk  (sys_clk),
        .async_in (power_stable),
        .sync_out (pwr_sync)
    );

    // Logic runs only while reset is inactive and power is stable
    // A power drop at any time clears the drive, fault, thermal and run flops, but not the synchronisers or mc_seen as the reset pin does
    assign live = st_q.rst_sync[1] & pwr_sync;

    always_comb begin
        st_d = st_q;
        st_d.rst_sync   = {st_q.rst_sync[0], 1'b1};
        st_d.mc_in_sync = {st_q.mc_in_sync[0], ~machine_check_error_n_in};
        st_d.seen       = st_q.mc_in_sync[1];
        st_d.run        = live;
        if (!live) begin
            // Outputs released within two clocks of reset seen
            st_d.mc_drive = 1'b0;
            st_d.fault    = 1'b0;
            st_d.hot      = 1'b0;
        end else begin
            // Internal fault is sticky until reset or a power drop
            if (internal_err) begin
                st_d.fault = 1'b1;
            end
            st_d.hot = die_at_limit;
            // Enable gates every machine check source
            if (mc_config[CFG_ENABLE]) begin
                if (internal_err && mc_config[CFG_INTERNAL]) begin
                    st_d.mc_drive = 1'b1;
                end
                if (initiator_err && mc_config[CFG_INITIATOR]) begin
                    st_d.mc_drive = 1'b1;
                end
                if (observed_err) begin
                    st_d.mc_drive = 1'b1;
                end
            end
        end
    end

    // Synchronous reset loads constants; pin reset release passes two flops for clean timing
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.rst_sync   <= SYNC_RESET;
            st_q.mc_in_sync <= SYNC_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Pins straight from flops, except machine_check_error_n_out, which is tied low; core_run and mc_seen are active high
    assign machine_check_error_n_out = 1'b0;
    assign machine_check_error_n_oe  = st_q.mc_drive;
    assign internal_fault_n          = ~st_q.fault;
    assign thermal_limit_n           = ~st_q.hot;
    assign core_run                  = st_q.run;
    assign mc_seen                   = st_q.seen;

    // Assertions
    sequence s_int_err_cfg;
        internal_err && live && mc_config[CFG_ENABLE] && mc_config[CFG_INTERNAL];
    endsequence

    a_mc_internal: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_int_err_cfg |=> machine_check_error_n_oe && !internal_fault_n)
        else $error("machine check not raised with internal fault");

    a_mc_disabled: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!machine_check_error_n_oe && !mc_config[CFG_ENABLE]) |=> !machine_check_error_n_oe)
        else $error("machine check raised while disabled");

    a_mc_initiator: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (initiator_err && live && mc_config[CFG_ENABLE] && mc_config[CFG_INITIATOR])
        |=> machine_check_error_n_oe)
        else $error("initiator error not signalled");

    a_mc_observed: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (observed_err && live && mc_config[CFG_ENABLE]) |=> machine_check_error_n_oe)
        else $error("observed error not signalled");

    a_fault_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!internal_fault_n && live) |=> !internal_fault_n)
        else $error("internal fault dropped before reset");

    a_reset_release: assert property (@(posedge sys_clk)
        !reset_n ##1 !reset_n |-> machine_check_error_n_oe == 1'b0 && internal_fault_n && thermal_limit_n)
        else $error("outputs not released within two clocks of reset");

    a_thermal_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (die_at_limit && live) |=> !thermal_limit_n)
        else $error("thermal limit not asserted");

    a_power_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!power_stable [*3]) |=> !core_run)
        else $error("core running without stable power");

    // Two synchroniser flops plus the seen register give three clocks of latency
    a_mc_shared: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!machine_check_error_n_in) ##1 (!machine_check_error_n_in) |=> ##1 mc_seen)
        else $error("shared machine check not observed");
endmodule : etp_top

// ### rtl/etp_pkg.sv
// Purpose: Constants for the error, thermal and power-stable sideband block.
// Assumes: Bus clock of 10 MHz; all sideband pins are active low except power_stable, core_run and mc_seen.
// Notes: Operation list follows.
// Operation
// - Assert machine check on unrecoverable non-protocol error
// - Machine check line shared by all agents
// - Machine check conditions configurable, including disable
// - Internal error drives machine check when configured
// - Initiator asserts machine check on own error
// - Any observer of bus error asserts machine check
// - Thermal limit output when die too hot
// - Power stable may drop; rise only when stable
// - Internal fault held until reset; the code also clears it when power stable drops
// - Outputs released within two clocks of reset
package etp_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned RESET_CLR_CYCLES = 2;  // Outputs released within this many clocks
    localparam logic [1:0]  SYNC_RESET      = 2'h0;
    // Configuration bit positions of mc_config
    localparam int unsigned CFG_ENABLE      = 0;
    localparam int unsigned CFG_INTERNAL    = 1;
    localparam int unsigned CFG_INITIATOR   = 2;
    localparam int unsigned CFG_WIDTH       = 3;
endpackage : etp_pkg

// ### rtl/etp_sync.sv
// Purpose: Two-flop synchroniser for asynchronous level inputs.
// Assumes: Input is a slow level; metastability settles within one clock.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ns
module etp_sync (
    input  wire logic sys_clk,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    // Deliberately no reset: the power-stable path must work before reset releases
    always_ff @(posedge sys_clk) begin
        meta_q   <= async_in;
        sync_out <= meta_q;
    end
endmodule : etp_sync

// ### sim/etp_far_side.sv
// Purpose: Far side: power sequencer and one more agent on the shared line.
// Assumes: Shared line is open drain with a board pull-up.
// Notes: Power level is clean, rises once per request, may drop at any time.
`timescale 1ns/1ns
module etp_far_side (
    input  wire logic pwr_req,
    input  wire logic agent_pull,
    input  wire logic dut_oe,
    output logic      power_stable,
    output logic      mc_line_n
);
    // Follows pwr_req directly: glitch-free, drops whenever the bench drops pwr_req
    assign power_stable = pwr_req;
    // Wired-AND: any agent pulling low wins over the pull-up
    assign mc_line_n = ~(dut_oe | agent_pull);
endmodule : etp_far_side

// ### sim/etp_top_bench.sv
// Purpose: Self-checking bench for the sideband block.
// Assumes: Inputs change on the falling edge.
// Notes: Sticky outputs are checked two edges after the event.
`timescale 1ns/1ns
module etp_top_bench;
    import etp_pkg::*;
    logic                 sys_clk, reset_n, pwr_req, agent_pull, int_e, ini_e, obs_e, hot;
    logic [CFG_WIDTH-1:0] cfg;
    logic                 pwr, line_n, oe, fault_n, therm_n, run, seen, mc_out;
    int                   miscompares, n_compared;
    etp_far_side far (.pwr_req(pwr_req), .agent_pull(agent_pull), .dut_oe(oe), .power_stable(pwr),
                      .mc_line_n(line_n));
    etp_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .power_stable(pwr), .mc_config(cfg),
                 .internal_err(int_e), .initiator_err(ini_e), .observed_err(obs_e), .die_at_limit(hot),
                 .machine_check_error_n_in(line_n), .machine_check_error_n_out(mc_out),
                 .machine_check_error_n_oe(oe), .internal_fault_n(fault_n), .thermal_limit_n(therm_n),
                 .core_run(run), .mc_seen(seen));
    task automatic chk(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : ticks
    task automatic pulse(ref logic s);
        s = 1'b1;
        ticks(1);
        s = 1'b0;
        ticks(2);
    endtask : pulse
    // Reset pulse well under the upper limit, then a bounded wait for the core
    task automatic restart();
        int k;
        reset_n = 1'b0;
        ticks(8);
        reset_n = 1'b1;
        for (k = 0; k < 20 && run !== 1'b1; k++) ticks(1);
        chk("core_run", 1'b1, run);
    endtask : restart
    task automatic t_internal();
        cfg = 3'h3;
        pulse(int_e);
        chk("oe", 1'b1, oe);
        chk("mc_out", 1'b0, mc_out);
        chk("fault_n", 1'b0, fault_n);
        ticks(5);
        chk("fault_n held", 1'b0, fault_n);
        reset_n = 1'b0;
        ticks(2);
        chk("oe rst", 1'b0, oe);
        chk("fault_n rst", 1'b1, fault_n);
        restart();
    endtask : t_internal
    // Internal and initiator sources gated by their option bits; enable bit gating checked on the observed source only
    task automatic t_gating();
        cfg = 3'h1;
        pulse(int_e);
        pulse(ini_e);
        chk("oe gated", 1'b0, oe);
        pulse(obs_e);
        chk("oe observed", 1'b1, oe);
        restart();
        cfg = 3'h6;
        pulse(obs_e);
        chk("oe disabled", 1'b0, oe);
        cfg = 3'h5;
        pulse(ini_e);
        chk("oe initiator", 1'b1, oe);
        restart();
    endtask : t_gating
    task automatic t_thermal();
        hot = 1'b1;
        ticks(2);
        chk("therm_n on", 1'b0, therm_n);
        hot = 1'b0;
        ticks(2);
        chk("therm_n off", 1'b1, therm_n);
    endtask : t_thermal
    // Another agent drives the shared line; this device must not echo it
    task automatic t_shared();
        agent_pull = 1'b1;
        ticks(4);
        chk("mc_seen", 1'b1, seen);
        chk("oe quiet", 1'b0, oe);
        agent_pull = 1'b0;
        restart();
    endtask : t_shared
    task automatic t_power();
        cfg = 3'h3;
        pulse(int_e);
        pwr_req = 1'b0;
        ticks(4);
        chk("oe pwr", 1'b0, oe);
        chk("run pwr", 1'b0, run);
        pwr_req = 1'b1;
        restart();
    endtask : t_power
    task automatic complete_run();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
    initial begin
        {reset_n, agent_pull, int_e, ini_e, obs_e, hot} = '0;
        cfg = 3'h0;
        pwr_req = 1'b1;
        restart();
        t_internal();
        t_gating();
        t_thermal();
        t_shared();
        t_power();
        complete_run();
    end
endmodule : etp_top_bench
